// ### flash_cpu.sv
// cpu end: avalon-mm registers drive table ops and firmware writes
`timescale 1ns/1ps
module flash_cpu
  import flash_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // link to the flash sequencer
  flash_if.cpu             link
);

  logic              ack_r;
  logic              take;
  logic [PTR_W-1:0]  ptr_r;
  logic [7:0]        data_r;
  logic [31:0]       rdata_r;
  logic              rd_r;
  logic              wr_r;
  logic              inc_r;
  logic              ctl_r;
  logic              unl_r;
  logic              clr_r;
  logic [7:0]        wdat_r;

  // a stalled core holds the bus, like a halted cpu
  assign avs_waitrequest = ~ack_r;
  assign avs_readdata    = rdata_r;
  assign take            = ack_r & (avs_read | avs_write);

  assign link.tbl_ptr   = ptr_r;
  assign link.tbl_rd    = rd_r;
  assign link.tbl_wr    = wr_r;
  assign link.tbl_wdata = data_r;
  assign link.ctl_wr    = ctl_r;
  assign link.ctl_wdata = wdat_r;
  assign link.unl_wr    = unl_r;
  assign link.unl_wdata = wdat_r;
  assign link.done_clr  = clr_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r & ~link.cpu_stall
               & ~rd_r & ~wr_r & ~ctl_r & ~unl_r;
      unique case (avs_address)
        OFS_POINTER: rdata_r <= {10'h000, ptr_r};
        OFS_DATA:    rdata_r <= {24'h000000, link.table_latch};
        OFS_CONTROL: rdata_r <= {24'h000000, link.ctl_rdata};
        OFS_STATUS:  rdata_r <= {30'h0, link.cpu_stall,
                                 link.nvm_done_flag};
        default:     rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // one-cycle orders to the sequencer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_r   <= 1'b0;
      wr_r   <= 1'b0;
      inc_r  <= 1'b0;
      ctl_r  <= 1'b0;
      unl_r  <= 1'b0;
      clr_r  <= 1'b0;
      wdat_r <= 8'h00;
      data_r <= 8'h00;
    end else begin
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
      ctl_r <= 1'b0;
      unl_r <= 1'b0;
      clr_r <= 1'b0;
      if (take && avs_write) begin
        unique case (avs_address)
          OFS_DATA:    data_r <= avs_writedata[7:0];
          OFS_COMMAND: begin
            // R12 one byte per order, firmware loops 64 times
            rd_r  <= avs_writedata[CMD_READ];
            wr_r  <= avs_writedata[CMD_WRITE] & ~avs_writedata[CMD_READ];
            inc_r <= avs_writedata[CMD_INC];
          end
          // R6 R13 firmware configures the control register
          OFS_CONTROL: begin
            ctl_r  <= 1'b1;
            wdat_r <= avs_writedata[7:0];
          end
          // R7 firmware writes the unlock bytes
          OFS_UNLOCK: begin
            unl_r  <= 1'b1;
            wdat_r <= avs_writedata[7:0];
          end
          OFS_STATUS:  clr_r <= avs_writedata[STS_DONE];
          default:     ;
        endcase
      end
    end
  end

  // pointer: written by software, post-incremented after a table op whose command sets CMD_INC
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_r <= '0;
    end else if (take && avs_write && avs_address == OFS_POINTER) begin
      ptr_r <= avs_writedata[PTR_W-1:0];
    end else if ((rd_r || wr_r) && inc_r) begin
      ptr_r <= {ptr_r[PTR_W-1], ptr_r[PTR_W-2:0] + 21'h000001};
    end
  end

endmodule

// ### flash_device.sv
// flash array end: table reads, holding block, unlock and long writes
//
// Operation
// R1 - one byte fetched per table read
// R2 - table read loads latch from pointer
// R3 - pointer bit zero picks word half
// R4 - erase unit is 32 words, 64 bytes
// R5 - erase uses pointer bits 21:6 only; the model takes the block from bits 12:6 (ARR_AW:BLK_LSB), upper bits alias
// R6 - firmware sets selects and enables before erase
// R7 - 55h then 0AAh unlock before start
// R8 - cpu stalled until timer ends write
// R9 - long write lasts about 2 ms
// R10 - programming works on whole 64-byte blocks
// R11 - 64 holding bytes; table writes hit them
// R12 - firmware issues 64 table writes per block
// R13 - configure, unlock, then holding block programmed
// R14 - holding bytes FFh on reset and completion
// R15 - FFh byte leaves flash byte unchanged
// R16 - partially loaded holding block still programs
// R17 - start bit set-only, hardware clears it
// R18 - done flag set, firmware clears it
// R19 - error flag on interrupted or bad start
// R20 - erase select clears when erase completes
// R21 - start ignored unless unlock immediately before
`timescale 1ns/1ps
module flash_device
  import flash_pkg::*;
#(
  parameter int unsigned LONG_WRITE_CYCLES = LW_CYCLES
) (
  // clock and resets
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic por_b,
  // link to the cpu side
  flash_if.dev      link,
  // status for the chip
  output logic      long_write_active
);

  // the array keeps no reset: it is nonvolatile
  logic [15:0]      mem [ARR_WORDS];
  logic [7:0]       hold_r [BLK_BYTES];
  logic [7:0]       latch_r;
  unlock_t          unl_r;
  logic             prog_sel_r;
  logic             cfg_sel_r;
  logic             erase_sel_r;
  logic             write_enable_bit_r;
  logic             wr_r;
  logic             err_r;
  logic             done_r;
  logic [TMR_W-1:0] tmr_r;
  logic [BASE_W-1:0] base_r;

  logic             start_req;
  logic             launch;
  logic             bad_start;
  logic             finish;
  logic [ARR_AW-1:0] rd_idx;
  logic [15:0]      rd_word;

  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(LONG_WRITE_CYCLES);
  localparam logic [TMR_W-1:0] TMR_ONE  = TMR_W'(1);

  assign start_req = link.ctl_wr & link.ctl_wdata[CTL_WR] & ~wr_r;
  // R21 unlock must be armed
  assign launch    = start_req & (unl_r == unl_armed) & write_enable_bit_r
                     & prog_sel_r & ~cfg_sel_r;
  assign bad_start = start_req & ~launch;
  assign finish    = wr_r & (tmr_r == TMR_ONE);

  // R8 stall while writing
  assign link.cpu_stall     = wr_r;
  assign long_write_active  = wr_r;
  assign link.table_latch   = latch_r;
  assign link.nvm_done_flag = done_r;
  assign link.ctl_rdata     = {prog_sel_r, cfg_sel_r, 1'b0, erase_sel_r,
                               err_r, write_enable_bit_r, wr_r, 1'b0};

  assign rd_idx  = link.tbl_ptr[ARR_AW:1];
  assign rd_word = mem[rd_idx];

  // R1 one byte per table read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      latch_r <= 8'h00;
    end else if (link.tbl_rd && !wr_r) begin
      // R2 latch from pointer; R3 bit zero picks high byte
      latch_r <= link.tbl_ptr[0] ? rd_word[15:8] : rd_word[7:0];
    end
  end

  // R11 table writes only fill the holding block
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < BLK_BYTES; i++) begin
        // R14 erased value on reset
        hold_r[i] <= BYTE_ERASED;
      end
    end else if (finish) begin
      for (int i = 0; i < BLK_BYTES; i++) begin
        // R14 erased value after write
        hold_r[i] <= BYTE_ERASED;
      end
    end else if (link.tbl_wr && !wr_r) begin
      hold_r[link.tbl_ptr[BLK_LSB-1:0]] <= link.tbl_wdata;
    end
  end

  // R7 unlock byte sequence
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      unl_r <= unl_idle;
    end else if (link.unl_wr) begin
      unique case (unl_r)
        unl_idle:  unl_r <= (link.unl_wdata == UNLOCK_FIRST) ?
                            unl_first : unl_idle;
        unl_first: unl_r <= (link.unl_wdata == UNLOCK_SECOND) ?
                            unl_armed : unl_idle;
        unl_armed: unl_r <= (link.unl_wdata == UNLOCK_FIRST) ?
                            unl_first : unl_idle;
      endcase
    end else if (link.ctl_wr || link.tbl_rd || link.tbl_wr) begin
      // R21 a control write, table read or table write disarms
      unl_r <= unl_idle;
    end
  end

  // selects and enables written by firmware
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prog_sel_r <= 1'b0;
      cfg_sel_r  <= 1'b0;
      write_enable_bit_r     <= 1'b0;
    end else if (link.ctl_wr && !wr_r) begin
      // R6 firmware chooses target and enable
      prog_sel_r <= link.ctl_wdata[CTL_PROG_SEL];
      cfg_sel_r  <= link.ctl_wdata[CTL_CFG_SEL];
      write_enable_bit_r     <= link.ctl_wdata[CTL_WRITE_ENABLE_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      erase_sel_r <= 1'b0;
    end else if (finish) begin
      // R20 erase select self-clears
      erase_sel_r <= 1'b0;
    end else if (link.ctl_wr && !wr_r) begin
      erase_sel_r <= link.ctl_wdata[CTL_ERASE_SEL];
    end
  end

  // R17 start bit set by launch, cleared only by hardware
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_r   <= 1'b0;
      tmr_r  <= '0;
      base_r <= '0;
    end else if (launch) begin
      wr_r   <= 1'b1;
      // R9 about 2 ms of timer
      tmr_r  <= TMR_LOAD;
      // R5 block from upper pointer bits
      base_r <= link.tbl_ptr[ARR_AW:BLK_LSB];
    end else if (finish) begin
      wr_r   <= 1'b0;
      tmr_r  <= '0;
    end else if (wr_r) begin
      tmr_r  <= tmr_r - TMR_ONE;
    end
  end

  // R19 only power-on or completion clears error, so a reset mid-write leaves it set
  always_ff @(posedge mclk or negedge por_b) begin
    if (!por_b) begin
      err_r <= 1'b0;
    end else if (launch || bad_start) begin
      err_r <= 1'b1;
    end else if (finish) begin
      err_r <= 1'b0;
    end
  end

  // R18 done flag, set wins over clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      done_r <= 1'b0;
    end else if (finish) begin
      done_r <= 1'b1;
    end else if (link.done_clr) begin
      done_r <= 1'b0;
    end
  end

  // R13 array updated when the timer ends the write
  always_ff @(posedge mclk) begin
    if (finish) begin
      for (int w = 0; w < BLK_WORDS; w++) begin
        if (erase_sel_r) begin
          // R4 whole 32-word block erased
          mem[{base_r, WORD_LSB'(w)}] <= WORD_ERASED;
        end else begin
          // R10 R16 whole block; R15 and-ing keeps FFh bytes
          mem[{base_r, WORD_LSB'(w)}] <= mem[{base_r, WORD_LSB'(w)}]
                                       & {hold_r[2*w+1], hold_r[2*w]};
        end
      end
    end
  end

endmodule

// ### flash_if.sv
// link between the cpu-side controller and the flash sequencer
`timescale 1ns/1ps
interface flash_if;
  logic [21:0] tbl_ptr;
  logic        tbl_rd;
  logic        tbl_wr;
  logic [7:0]  tbl_wdata;
  logic        ctl_wr;
  logic [7:0]  ctl_wdata;
  logic        unl_wr;
  logic [7:0]  unl_wdata;
  logic        done_clr;
  logic [7:0]  table_latch;
  logic [7:0]  ctl_rdata;
  logic        cpu_stall;
  logic        nvm_done_flag;
  modport dev (
    input  tbl_ptr, tbl_rd, tbl_wr, tbl_wdata, ctl_wr, ctl_wdata,
    input  unl_wr, unl_wdata, done_clr,
    output table_latch, ctl_rdata, cpu_stall, nvm_done_flag
  );
  modport cpu (
    output tbl_ptr, tbl_rd, tbl_wr, tbl_wdata, ctl_wr, ctl_wdata,
    output unl_wr, unl_wdata, done_clr,
    input  table_latch, ctl_rdata, cpu_stall, nvm_done_flag
  );
endinterface

// ### flash_monitor.sv
// link assertions for the flash sequencer pair
`timescale 1ns/1ps
module flash_monitor
  import flash_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_b,
  // link signals
  input wire logic       tbl_rd,
  input wire logic       ctl_wr,
  input wire logic [7:0] ctl_wdata,
  input wire logic       done_clr,
  input wire logic [7:0] table_latch,
  input wire logic [7:0] ctl_rdata,
  input wire logic       cpu_stall,
  input wire logic       nvm_done_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // bound window, since the timer count may round by an edge
  sequence seq_busy;
    cpu_stall [*7] ##[1:3] !cpu_stall;
  endsequence
  sequence seq_end;
    !ctl_rdata[CTL_ERASE_SEL] && !ctl_rdata[CTL_ERR];
  endsequence
  a_latch_hold: assert property (
    $changed(table_latch) |-> $past(tbl_rd)) else $error("latch moved");
  a_launch_cause: assert property (
    $rose(cpu_stall) |-> $past(ctl_wr) && $past(ctl_wdata[CTL_WR]))
    else $error("stall without start write");
  a_launch_err: assert property (
    $rose(cpu_stall) |-> ctl_rdata[CTL_ERR]) else $error("no error at start");
  a_busy_span: assert property (
    $rose(cpu_stall) |-> seq_busy) else $error("stall span wrong");
  a_stall_mirror: assert property (
    $fell(ctl_rdata[CTL_WR]) |-> nvm_done_flag)
    else $error("start bit cleared before completion");
  a_end_clears: assert property (
    $fell(cpu_stall) |-> seq_end) else $error("bits kept at end");
  a_done_on_end: assert property (
    $rose(nvm_done_flag) |-> $fell(cpu_stall)) else $error("stray done");
  a_done_sticky: assert property (
    nvm_done_flag && !done_clr |=> nvm_done_flag) else $error("done lost");
  a_bad_start: assert property (
    ctl_wr && ctl_wdata[CTL_WR] && !ctl_wdata[CTL_WRITE_ENABLE_BIT] && !cpu_stall
    |=> !cpu_stall && ctl_rdata[CTL_ERR]) else $error("bad start taken");
endmodule

// ### flash_pkg.sv
// shared constants for the flash self-programming sequencer
package flash_pkg;
  // table pointer and block geometry
  localparam int unsigned PTR_W      = 22;
  localparam int unsigned BLK_BYTES  = 64;
  localparam int unsigned BLK_WORDS  = 32;
  localparam int unsigned BLK_LSB    = 6;
  localparam int unsigned WORD_LSB   = 5;
  // modelled array: 2**ARR_AW words, upper pointer bits alias
  localparam int unsigned ARR_AW     = 12;
  localparam int unsigned ARR_WORDS  = 4096;
  localparam int unsigned BASE_W     = 7;
  localparam logic [7:0]  BYTE_ERASED = 8'hff;
  localparam logic [15:0] WORD_ERASED = 16'hffff;
  // unlock bytes
  localparam logic [7:0]  UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0]  UNLOCK_SECOND = 8'haa;
  // memory_control_reg bit positions
  localparam int unsigned CTL_PROG_SEL  = 7;
  localparam int unsigned CTL_CFG_SEL   = 6;
  localparam int unsigned CTL_ERASE_SEL = 4;
  localparam int unsigned CTL_ERR       = 3;
  localparam int unsigned CTL_WRITE_ENABLE_BIT      = 2;
  localparam int unsigned CTL_WR        = 1;
  // long write timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned LW_TIME_NS    = 2000000;
  localparam int unsigned LW_CYCLES     =
    (LW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W         = 16;
  // avalon register byte offsets
  localparam logic [4:0] OFS_POINTER = 5'h00;
  localparam logic [4:0] OFS_DATA    = 5'h04;
  localparam logic [4:0] OFS_COMMAND = 5'h08;
  localparam logic [4:0] OFS_CONTROL = 5'h0c;
  localparam logic [4:0] OFS_UNLOCK  = 5'h10;
  localparam logic [4:0] OFS_STATUS  = 5'h14;
  // command and status bits
  localparam int unsigned CMD_READ   = 0;
  localparam int unsigned CMD_WRITE  = 1;
  localparam int unsigned CMD_INC    = 2;
  localparam int unsigned STS_DONE   = 0;
  localparam int unsigned STS_STALL  = 1;
  typedef enum logic [1:0] {unl_idle, unl_first, unl_armed} unlock_t;
endpackage

// ### program_flash_self_programming_test.sv
// testbench for the flash sequencer pair over avalon-mm
`timescale 1ns/1ps
module program_flash_self_programming_test
  import flash_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        por_b = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        lw_active;
  int          errors = 0;
  int          n_tests = 0;
  flash_if link ();
  flash_cpu i_flash_cpu (.mclk(mclk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link));
  // short timer count keeps the run brief
  flash_device #(.LONG_WRITE_CYCLES(8)) i_flash_device (.mclk(mclk),
    .rst_b(rst_b), .por_b(por_b), .link(link),
    .long_write_active(lw_active));
  flash_monitor i_flash_monitor (.mclk(mclk), .rst_b(rst_b),
    .tbl_rd(link.tbl_rd), .ctl_wr(link.ctl_wr), .ctl_wdata(link.ctl_wdata),
    .done_clr(link.done_clr), .table_latch(link.table_latch),
    .ctl_rdata(link.ctl_rdata), .cpu_stall(link.cpu_stall),
    .nvm_done_flag(link.nvm_done_flag));
  always #50 mclk = ~mclk;
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // a stalled slave may hold waitrequest for the whole long write
  task automatic av(input logic [4:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // no cycle limit here: only the watchdog ends a hung wait
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(a, 1'b1, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    av(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  task automatic launch(input logic [7:0] c);
    wr(OFS_UNLOCK, {24'h0, UNLOCK_FIRST});
    wr(OFS_UNLOCK, {24'h0, UNLOCK_SECOND});
    wr(OFS_CONTROL, {24'h0, c});
  endtask
  task automatic rd_byte(input logic [21:0] p, input logic [7:0] e);
    wr(OFS_POINTER, {10'h0, p});
    wr(OFS_COMMAND, 32'h1);
    rdc(OFS_DATA, {24'h0, e});
  endtask
  task automatic ld_byte(input logic [21:0] p, input logic [7:0] d);
    wr(OFS_POINTER, {10'h0, p});
    wr(OFS_DATA, {24'h0, d});
    wr(OFS_COMMAND, 32'h2);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    @(posedge mclk);
    rdc(OFS_CONTROL, 32'h0);
    wr(5'h18, 32'hff);
    rdc(5'h18, 32'h0);
    wr(OFS_POINTER, 32'h45);
    wr(OFS_CONTROL, 32'h94);
    launch(8'h96);
    rdc(OFS_CONTROL, 32'h84);
    rdc(OFS_STATUS, 32'h1);
    wr(OFS_STATUS, 32'h1);
    rdc(OFS_STATUS, 32'h0);
    wr(OFS_POINTER, 32'h40);
    for (int i = 0; i < BLK_BYTES; i++) begin
      wr(OFS_COMMAND, 32'h5);
      rdc(OFS_DATA, 32'hff);
    end
    rdc(OFS_POINTER, 32'h80);
    ld_byte(22'h40, 8'h12);
    ld_byte(22'h41, 8'h34);
    ld_byte(22'h7f, 8'h5a);
    wr(OFS_CONTROL, 32'h84);
    launch(8'h86);
    rd_byte(22'h40, 8'h12);
    rd_byte(22'h41, 8'h34);
    rd_byte(22'h42, 8'hff);
    rd_byte(22'h7f, 8'h5a);
    // only one byte loaded: the rest must keep their programmed values
    ld_byte(22'h40, 8'h0f);
    launch(8'h86);
    rd_byte(22'h40, 8'h02);
    rd_byte(22'h41, 8'h34);
    rd_byte(22'h7f, 8'h5a);
    // second block: erase, empty program, then 64 table writes
    wr(OFS_POINTER, 32'h80);
    wr(OFS_CONTROL, 32'h94);
    launch(8'h96);
    wr(OFS_CONTROL, 32'h84);
    launch(8'h86);
    // stale holding bytes would show through here
    rd_byte(22'h81, 8'hff);
    wr(OFS_POINTER, 32'h80);
    for (int i = 0; i < BLK_BYTES; i++) begin
      wr(OFS_DATA, 32'(i));
      wr(OFS_COMMAND, 32'h6);
    end
    wr(OFS_POINTER, 32'h80);
    launch(8'h86);
    rd_byte(22'h80, 8'h00);
    rd_byte(22'h81, 8'h01);
    rd_byte(22'hbf, 8'h3f);
    wr(OFS_CONTROL, 32'h80);
    launch(8'h82);
    rdc(OFS_CONTROL, 32'h88);
    wr(OFS_CONTROL, 32'h84);
    wr(OFS_UNLOCK, 32'h55);
    wr(OFS_UNLOCK, 32'h11);
    wr(OFS_CONTROL, 32'h86);
    rdc(OFS_CONTROL, 32'h8c);
    wr(OFS_UNLOCK, 32'h55);
    wr(OFS_UNLOCK, 32'haa);
    wr(OFS_COMMAND, 32'h1);
    wr(OFS_CONTROL, 32'h86);
    rdc(OFS_CONTROL, 32'h8c);
    rd_byte(22'h40, 8'h02);
    launch(8'h86);
    repeat (3) @(posedge mclk);
    chk({31'h0, lw_active}, 32'h1);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rdc(OFS_CONTROL, 32'h08);
    chk({31'h0, lw_active}, 32'h0);
    final_report;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    final_report;
  end
endmodule
